// ===== design/spdif_cs_pkg.sv
// Shared constants and carrier types for the channel status capture block.
// Assumes one system clock domain; offsets are the register addresses of the
// serial control interface read-back port.
package spdif_cs_pkg;

  // Read-back addresses of the three capture registers.
  localparam logic [6:0] SOURCE_CHANNEL_OFFSET = 7'h0f;
  localparam logic [6:0] RATE_ACCURACY_OFFSET  = 7'h10;
  localparam logic [6:0] WORD_LENGTH_OFFSET    = 7'h11;

  // Captured span is channel status bits 16 to 39, held as a 24-bit vector.
  localparam int unsigned CS_FIRST_BIT = 16;
  localparam int unsigned CS_SPAN      = 24;
  localparam logic [7:0]  CS_FIRST_IDX = 8'h10;
  localparam logic [7:0]  CS_LAST_IDX  = 8'h27;
  localparam logic [7:0]  BLOCK_LAST   = 8'hbf;

  // Reset image: rate 0001, accuracy 11, max length selector 1, rest zero.
  localparam logic [23:0] CS_RESET = 24'h013100;

  // Field positions inside the 24-bit capture vector (bit n = status bit n+16).
  localparam int unsigned SRC_LSB   = 0;
  localparam int unsigned RATE_LSB  = 8;
  localparam int unsigned MAX_LENGTH_SELECTOR_POS = 16;
  localparam int unsigned WL_LSB    = 17;
  localparam int unsigned ORG_LSB   = 20;

  // Audio sample width carried by the receiver.
  localparam int unsigned SAMPLE_W     = 24;
  localparam logic [4:0]  FULL_LENGTH  = 5'h18;

  // One recovered channel status bit from the front end.
  typedef struct packed {
    logic valid;
    logic status_bit;
    logic subframe_a;
    logic block_start;
  } cs_bit_t;

  // One audio sample with its strobe.
  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

endpackage

// ===== design/spdif_channel_status_regs.sv
// Channel status capture registers, word length decode and sample truncation.
// Assumes the receiver front end delivers one status bit per subframe, flags
// subframe A and marks frame 0 of each 192-frame block; reads are synchronous.
//
// Operation
// - Status bits 19:16 and 21:20 go to register bits 3:0 and 5:4.
// - Status bits 23:22 go to register bits 7:6, reset zero.
// - Status bits 27:24 read as bits 3:0 of rate register, reset 0001.
// - Status bits 29:28 read as clock accuracy bits 5:4, reset 11.
// - Bit 32 is max length selector, reset 1; bits 35:33 word length code.
// - Decode codes 001,010,100,101,110 to lengths, selector adds four bits.
// - Outgoing samples have bits below decoded length forced to zero.
// - Mask bit set passes all sample bits unchanged.
// - Registers update and event rises only at last bit of a changed block.
// - Only channel one subframe status bits are captured.
// - Update event stays high until software reads a status register or a new differing bit arrives.
`timescale 1ns/1ps

module spdif_channel_status_regs
  import spdif_cs_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_sys_in,
  input  wire logic                nrst_in,
  // Recovered channel status from the receiver front end.
  input  wire cs_bit_t             cs_bit_in,
  // Audio path towards the transmitter.
  input  wire sample_t             sample_in,
  input  wire logic                truncation_mask_bit_in,
  output sample_t                  sample_out,
  // Register read-back port.
  input  wire logic                rd_en_in,
  input  wire logic [6:0]          rd_addr_in,
  output logic [7:0]               rd_data_out,
  // Status event and decoded length.
  output logic                     channel_status_update_event_out,
  output logic [4:0]               word_length_out
);

  // Decodes the received word length; unknown codes mean full width.
  function automatic logic [4:0] decode_length(input logic max_sel, input logic [2:0] code);
    logic [4:0] len;
    len = FULL_LENGTH;
    case (code)
      3'h1:    len = max_sel ? 5'h14 : 5'h10;
      3'h2:    len = max_sel ? 5'h16 : 5'h12;
      3'h4:    len = max_sel ? 5'h17 : 5'h13;
      3'h5:    len = max_sel ? 5'h18 : 5'h14;
      3'h6:    len = max_sel ? 5'h15 : 5'h11;
      default: len = FULL_LENGTH;
    endcase
    return len;
  endfunction

  logic [23:0]         cs_q;
  logic [23:0]         shadow_q;
  logic [7:0]          idx_q;
  logic                synced_q;
  logic                event_q;
  logic [7:0]          rd_data_q;
  sample_t             sample_q;

  // Bit position decode; subframe B is ignored since stereo is assumed.
  wire        take_bit   = cs_bit_in.valid && cs_bit_in.subframe_a;
  wire [7:0]  cur_idx    = cs_bit_in.block_start ? 8'h00 : idx_q + 8'h01;
  wire        counting   = take_bit && (synced_q || cs_bit_in.block_start);
  wire        in_span    = (cur_idx >= CS_FIRST_IDX) && (cur_idx <= CS_LAST_IDX);
  wire [4:0]  span_pos   = 5'(cur_idx - CS_FIRST_IDX);
  wire        capture    = counting && in_span;
  wire        diff_bit   = capture && (cs_bit_in.status_bit != cs_q[span_pos]);
  wire        last_bit   = counting && (cur_idx == BLOCK_LAST);
  wire        changed    = last_bit && (shadow_q != cs_q);

  // Register read decode.
  wire        hit_src    = rd_addr_in == SOURCE_CHANNEL_OFFSET;
  wire        hit_rate   = rd_addr_in == RATE_ACCURACY_OFFSET;
  wire        hit_wl     = rd_addr_in == WORD_LENGTH_OFFSET;
  wire        rd_hit     = rd_en_in && (hit_src || hit_rate || hit_wl);

  // Register images; bits 30 and 31 are not part of any register.
  wire [7:0]  src_image  = cs_q[SRC_LSB +: 8];
  wire [7:0]  rate_image = {2'h0, cs_q[RATE_LSB +: 6]};
  wire [7:0]  wl_image   = {cs_q[ORG_LSB +: 4], cs_q[WL_LSB +: 3], cs_q[MAX_LENGTH_SELECTOR_POS]};
  wire [7:0]  rd_data_d  = !rd_en_in ? rd_data_q :
                           hit_src   ? src_image :
                           hit_rate  ? rate_image :
                           hit_wl    ? wl_image : 8'h00;

  // Word length decode and truncation mask.
  wire [4:0]  wl_len     = decode_length(cs_q[MAX_LENGTH_SELECTOR_POS], cs_q[WL_LSB +: 3]);
  wire [4:0]  drop_bits  = 5'(FULL_LENGTH - wl_len);
  wire [23:0] keep_mask  = ~((24'h000001 << drop_bits) - 24'h000001);
  wire [23:0] trunc_data = truncation_mask_bit_in ? sample_in.data :
                           (sample_in.data & keep_mask);

  // The event is set at the end of a changed block; a set beats a clear,
  // and a fresh differing bit withdraws the pending event until block end.
  wire        event_d    = changed ? 1'b1 :
                           (rd_hit || diff_bit) ? 1'b0 : event_q;

  // Block position tracking; nothing is counted before the first block start.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_q    <= 8'h00;
      synced_q <= 1'b0;
    end else if (counting) begin
      idx_q    <= cur_idx;
      synced_q <= 1'b1;
    end
  end

  // Shadow capture of the span, one flip-flop per status bit.
  genvar g;
  generate
    for (g = 0; g < CS_SPAN; g++) begin : g_shadow
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          shadow_q[g] <= CS_RESET[g];
        end else if (capture && span_pos == 5'(g)) begin
          shadow_q[g] <= cs_bit_in.status_bit;
        end
      end
    end
  endgenerate

  // Visible registers change only when a whole differing block has arrived.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_q <= CS_RESET;
    end else if (changed) begin
      cs_q <= shadow_q;
    end
  end

  // Event, read data and truncated sample registers.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      event_q   <= 1'b0;
      rd_data_q <= 8'h00;
      sample_q  <= '0;
    end else begin
      event_q   <= event_d;
      rd_data_q <= rd_data_d;
      sample_q  <= '{valid: sample_in.valid, data: trunc_data};
    end
  end

  assign sample_out                      = sample_q;
  assign rd_data_out                     = rd_data_q;
  assign channel_status_update_event_out = event_q;
  assign word_length_out                 = wl_len;

  // Source and channel number fields read back from their status bits.
  property p_src_read;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (rd_en_in && hit_src) |=> (rd_data_out == $past(cs_q[7:0]));
  endproperty
  a_src_read: assert property (p_src_read) else $error("source register read mismatch");

  // Subframe-2 channel number occupies the top two bits of that register.
  property p_subframe2_channel_number_read;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (rd_en_in && hit_src) |=> (rd_data_out[7:6] == $past(cs_q[7:6]));
  endproperty
  a_subframe2_channel_number_read: assert property (p_subframe2_channel_number_read) else $error("channel number 2 mismatch");

  // Rate and accuracy fields with zero top bits.
  property p_rate_read;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (rd_en_in && hit_rate) |=> (rd_data_out == {2'h0, $past(cs_q[13:8])});
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate register read mismatch");

  // Word length register packs selector, code and original rate.
  property p_wl_read;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (rd_en_in && hit_wl) |=> (rd_data_out == {$past(cs_q[23:17]), $past(cs_q[16])});
  endproperty
  a_wl_read: assert property (p_wl_read) else $error("word length register mismatch");

  // Code 101 means a 24-bit word with the selector high and a 20-bit word with it low.
  property p_decode;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (cs_q[19:17] == 3'h5) |-> (word_length_out == (cs_q[16] ? 5'h18 : 5'h14));
  endproperty
  a_decode: assert property (p_decode) else $error("word length decode wrong");

  // A 16-bit word clears the low eight sample bits when unmasked.
  property p_truncate;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (!truncation_mask_bit_in && wl_len == 5'h10) |=> (sample_out.data[7:0] == 8'h00);
  endproperty
  a_truncate: assert property (p_truncate) else $error("truncation not applied");

  // Masked samples pass untouched.
  property p_mask;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    truncation_mask_bit_in |=> (sample_out.data == $past(sample_in.data));
  endproperty
  a_mask: assert property (p_mask) else $error("masked sample altered");

  // Registers only move on the last bit of a differing block.
  property p_update_only_last;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !changed |=> $stable(cs_q);
  endproperty
  a_update_only_last: assert property (p_update_only_last) else $error("registers moved early");

  // Event rises exactly one cycle after a changed block end.
  property p_event_rise;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(channel_status_update_event_out) |-> $past(changed) && (cs_q == $past(shadow_q));
  endproperty
  a_event_rise: assert property (p_event_rise) else $error("event rose without update");

  // Subframe B bits leave the block position and shadow alone.
  property p_ignore_b;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (cs_bit_in.valid && !cs_bit_in.subframe_a) |=> ($stable(idx_q) && $stable(shadow_q));
  endproperty
  a_ignore_b: assert property (p_ignore_b) else $error("subframe B captured");

  // The event holds until a read or a new differing bit.
  property p_event_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (event_q && !rd_hit && !diff_bit) |=> event_q;
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("event dropped early");

  // A read without a simultaneous update clears the event.
  property p_event_clear;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (rd_hit && !changed) |=> !channel_status_update_event_out;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("read did not clear event");

endmodule

// ===== verif/spdif_rx_front_model.sv
// Behavioural receiver front end that sends one channel status block on request.
// Assumes the bench raises go_in for one cycle and then waits for busy_out to drop.
`timescale 1ns/1ps

module spdif_rx_front_model
  import spdif_cs_pkg::*;
(
  // Clock and request.
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [23:0] payload_in,
  // Recovered bits towards the block.
  output cs_bit_t          cs_bit_out,
  output logic             busy_out
);
  logic cs_val;

  // Each frame sends an A pulse, then a B pulse that carries the inverse bit.
  // A block that listened to subframe B would capture the wrong payload.
  initial begin
    cs_bit_out = '0;
    busy_out   = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out = 1'b1;
        for (int f = 0; f < 192; f++) begin
          cs_val = (f >= 16 && f < 40) ? payload_in[f-16] : 1'b0;
          #1 cs_bit_out = {1'b1, cs_val, 1'b1, f == 0};
          @(posedge clk_in);
          #1 cs_bit_out = {1'b1, ~cs_val, 1'b0, 1'b0};
          @(posedge clk_in);
          #1 cs_bit_out = {1'b0, cs_val, 2'b00}; // Idle lines show the stale A bit.
          @(posedge clk_in);
        end
        // Dropped just after the edge so the bench never races it.
        #1 busy_out = 1'b0;
      end
    end
  end
endmodule

// ===== verif/test_spdif_channel_status_regs.sv
// Self-checking bench for the channel status capture registers.
// Assumes the front end model delivers whole blocks and reads answer one cycle later.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module test_spdif_channel_status_regs;
  import spdif_cs_pkg::*;
  logic        clk_sys_in, nrst_in, go, mask, rd_en, busy, upd_event;
  logic [23:0] payload, p;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  logic [4:0]  wl;
  cs_bit_t     cs_bit;
  sample_t     s_in, s_out;
  int          n_errors, checked;
  // Rows are {selector, code, expected length}; the last two codes are unlisted.
  localparam logic [8:0] ROWS [12] = '{9'h134, 9'h156, 9'h197, 9'h1b8, 9'h1d5, 9'h030,
                                       9'h052, 9'h093, 9'h0b4, 9'h0d1, 9'h018, 9'h1f8};

  spdif_channel_status_regs i_spdif_channel_status_regs (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .cs_bit_in(cs_bit), .sample_in(s_in), .truncation_mask_bit_in(mask),
    .sample_out(s_out), .rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .channel_status_update_event_out(upd_event), .word_length_out(wl));
  spdif_rx_front_model i_spdif_rx_front_model (.clk_in(clk_sys_in), .go_in(go),
    .payload_in(payload), .cs_bit_out(cs_bit), .busy_out(busy));

  // Free-running system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One read strobe; data is registered, so it is looked at one edge later.
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk_sys_in);
    #1 rd_en = 1'b0;
    `CHK(rd_data, exp)
  endtask

  // Sends one block and waits, bounded, until its last bit has been taken.
  task automatic send(input logic [23:0] v);
    int n;
    @(posedge clk_sys_in);
    #1 payload = v;
    go = 1'b1;
    @(posedge clk_sys_in);
    #1 go = 1'b0;
    n = 0;
    while (busy && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (busy) n_errors++;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  // One sample through the audio path, checked on the following cycle.
  task automatic samp(input logic m, input logic [23:0] exp);
    @(posedge clk_sys_in);
    #1 mask = m;
    s_in = {1'b1, 24'ha5c3f9};
    @(posedge clk_sys_in);
    #1 s_in = '0;
    `CHK(s_out, {1'b1, exp})
  endtask

  // Watchdog sized well beyond fifteen blocks of about six hundred cycles.
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    n_errors = 0;
    checked = 0;
    go = 1'b0;
    mask = 1'b0;
    rd_en = 1'b0;
    rd_addr = '0;
    payload = '0;
    p = '0;
    s_in = '0;
    nrst_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    `CHK(upd_event, 1'b0)
    `CHK(wl, FULL_LENGTH)
    rd(SOURCE_CHANNEL_OFFSET, 8'h00);
    rd(RATE_ACCURACY_OFFSET, 8'h31);
    rd(WORD_LENGTH_OFFSET, 8'h01);
    $display("test reset done");
    // Every listed code under both selectors, plus unlisted codes, all accuracy codes.
    for (int i = 0; i < 12; i++) begin
      p = {i[3:0], ROWS[i][7:5], ROWS[i][8], 2'b00, i[1:0], i[3:0] ^ 4'h5, ~i[1:0], i[1:0],
           ~i[3:0]};
      send(p);
      `CHK(upd_event, 1'b1)
      rd(SOURCE_CHANNEL_OFFSET, p[7:0]);
      `CHK(upd_event, 1'b0)
      rd(RATE_ACCURACY_OFFSET, {2'b00, p[13:8]});
      rd(WORD_LENGTH_OFFSET, p[23:16]);
      `CHK(wl, ROWS[i][4:0])
      samp(1'b0, 24'ha5c3f9 & (24'hffffff << (5'd24 - ROWS[i][4:0])));
      samp(1'b1, 24'ha5c3f9);
      $display("test row %0d done", i);
    end
    // An unchanged block must not raise the event or alter the registers.
    send(p);
    `CHK(upd_event, 1'b0)
    rd(WORD_LENGTH_OFFSET, p[23:16]);
    rd(7'h12, 8'h00);
    $display("test repeat block done");
    // A pending event is withdrawn by the first differing bit and set again at block end.
    send(p ^ 24'h000001);
    `CHK(upd_event, 1'b1)
    fork
      send(p);
      begin
        repeat (60) @(posedge clk_sys_in);
        #1;
        `CHK(upd_event, 1'b0)
      end
    join
    `CHK(upd_event, 1'b1)
    $display("test event withdraw done");
    // Reset in mid-run, with an event pending, brings back the reset image.
    @(posedge clk_sys_in);
    #1 nrst_in = 1'b0;
    @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    `CHK(upd_event, 1'b0)
    rd(WORD_LENGTH_OFFSET, 8'h01);
    rd(RATE_ACCURACY_OFFSET, 8'h31);
    rd(SOURCE_CHANNEL_OFFSET, 8'h00);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
